//--- rtl/slt_pkg.sv
// Constants shared by the sector lock and training pattern register block.
// Assumes a command decoder on the same clock presents decoded operations.
package slt_pkg;
    // ========================================
    // Operation codes
    localparam logic [2:0] SLT_OP_RD_LOCK   = 3'h0;
    localparam logic [2:0] SLT_OP_WR_LOCK   = 3'h1;
    localparam logic [2:0] SLT_OP_RD_STORED = 3'h2;
    localparam logic [2:0] SLT_OP_WR_STORED = 3'h3;
    localparam logic [2:0] SLT_OP_RD_LIVE   = 3'h4;
    localparam logic [2:0] SLT_OP_WR_LIVE   = 3'h5;
    localparam logic [2:0] SLT_OP_RD_STATE  = 3'h6;
    // ========================================
    // Delivery state items
    localparam logic [2:0] SLT_ITEM_ARRAY   = 3'h0;
    localparam logic [2:0] SLT_ITEM_OTP     = 3'h1;
    localparam logic [2:0] SLT_ITEM_STATUS1 = 3'h2;
    localparam logic [2:0] SLT_ITEM_CONFIG1 = 3'h3;
    localparam logic [2:0] SLT_ITEM_BOOT    = 3'h4;
    localparam logic [2:0] SLT_ITEM_PASS    = 3'h5;
    localparam logic [2:0] SLT_ITEM_PLOCK   = 3'h6;
    localparam logic [2:0] SLT_ITEM_ASP     = 3'h7;
    // ========================================
    // Values
    localparam logic [7:0]  SLT_LOCK_CLEAR     = 8'h00;
    localparam logic [7:0]  SLT_LOCK_SET       = 8'hff;
    localparam logic [7:0]  SLT_STORED_RESET   = 8'h00;
    localparam logic [7:0]  SLT_ERASED_BYTE    = 8'hff;
    localparam logic [7:0]  SLT_STATUS1_RESET  = 8'h00;
    localparam logic [7:0]  SLT_CONFIG1_RESET  = 8'h00;
    localparam logic [7:0]  SLT_BOOT_RESET     = 8'h00;
    localparam logic [63:0] SLT_PASS_RESET     = 64'hffff_ffff_ffff_ffff;
    localparam logic [15:0] SLT_ASP_RESET      = 16'hfe7f;
    localparam int          SLT_OTP_SEED_BYTES = 16;
    localparam int          SLT_PATTERN_BITS   = 8;
endpackage

//--- rtl/slt_pat_if.sv
// Link between the register block and the training pattern driver.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface slt_pat_if;
    logic [7:0] pattern;
    logic       start;
    logic       tick;
    logic       bit_val;
    logic       busy;
    modport regs (output pattern, output start, output tick, input bit_val, input busy);
    modport drv  (input pattern, input start, input tick, output bit_val, output busy);
endinterface
`default_nettype wire

//--- rtl/slt_pattern_drive.sv
// Shifts the live training pattern out, most significant bit first.
// Assumes start and tick come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module slt_pattern_drive
    import slt_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    slt_pat_if.drv    pat
);
    logic [7:0] shift_q;
    logic [3:0] left_q;

    // ========================================
    // Shifter
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            shift_q <= 8'h00;
            left_q  <= 4'h0;
        end else if (pat.start) begin
            shift_q <= pat.pattern;
            left_q  <= 4'(SLT_PATTERN_BITS);
        end else if (pat.tick && left_q != 4'h0) begin
            shift_q <= {shift_q[6:0], 1'b0};
            left_q  <= left_q - 4'h1;
        end
    end

    assign pat.bit_val = shift_q[7];
    assign pat.busy    = (left_q != 4'h0);
endmodule
`default_nettype wire

//--- rtl/slt_regs.sv
// Sector dynamic lock bits, training pattern registers and delivery state.
// Assumes a command decoder on clk_i presents one decoded operation a cycle.
// ========================================
// Summary of operation
// - Writing 00h clears sector lock bit, protecting
// - Writing FFh sets lock bit; default FFh
// - Eight-bit stored pattern, delivered 00h, trains capture
// - Live copy drives pattern; host may overwrite
// - Main array bytes read FFh as delivered
// - First 16 OTP bytes random, rest FFh
// - First status register reads 00h
// - First configuration register reads 00h
// - Automatic boot register reads 00h
// - Hidden password register holds all ones
// - All persistent sector lock bits one
// - Advanced protection register holds FE7Fh
`timescale 1ns/10ps
`default_nettype none
module slt_regs
    import slt_pkg::*;
#(
    parameter int          SECTORS  = 512,
    parameter int          SECT_W   = $clog2(SECTORS),
    parameter logic [127:0] OTP_SEED = 128'h5a3c_96e1_0f7b_d248_c3a5_1e69_87f0_2b4d // Arbitrary value
)(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              cmd_valid_i,
    input  wire logic [2:0]        cmd_op_i,
    input  wire logic [SECT_W-1:0] cmd_sector_i,
    input  wire logic [2:0]        cmd_item_i,
    input  wire logic [9:0]        cmd_index_i,
    input  wire logic [7:0]        cmd_wdata_i,
    input  wire logic              train_start_i,
    input  wire logic              train_tick_i,
    output logic                   rd_valid_o,
    output logic [7:0]             rd_data_o,
    output logic                   sector_locked_o,
    output logic                   train_bit_o,
    output logic                   train_oe_n_o
);
    // ========================================
    // Storage
    logic [SECTORS-1:0] lock_bits_q;
    logic [7:0]         stored_q;
    logic               stored_done_q;
    logic [7:0]         live_q;
    logic               rst_seen_q;
    logic [7:0]         state_byte;
    logic               wr_lock;
    logic               wr_stored;
    logic               wr_live;

    // ========================================
    // Link to the pattern driver
    slt_pat_if pat ();

    // ========================================
    // Helpers
    function automatic logic [7:0] pick_byte(input logic [127:0] v, input logic [3:0] idx);
        pick_byte = v[{idx, 3'h0} +: 8];
    endfunction

    function automatic logic op_hit(input logic       valid,
                                    input logic [2:0] got,
                                    input logic [2:0] want);
        op_hit = valid && got == want;
    endfunction

    function automatic logic sector_bit(input logic [SECTORS-1:0] bits,
                                        input logic [SECT_W-1:0]  idx);
        sector_bit = bits[idx];
    endfunction

    function automatic logic [7:0] lock_byte(input logic unlocked);
        lock_byte = unlocked ? SLT_LOCK_SET : SLT_LOCK_CLEAR;
    endfunction

    // ========================================
    // Write strobes
    assign wr_lock   = op_hit(cmd_valid_i, cmd_op_i, SLT_OP_WR_LOCK);
    assign wr_stored = op_hit(cmd_valid_i, cmd_op_i, SLT_OP_WR_STORED);
    assign wr_live   = op_hit(cmd_valid_i, cmd_op_i, SLT_OP_WR_LIVE);

    // ========================================
    // Sector dynamic lock bits
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lock_bits_q <= '1;
        end else if (wr_lock) begin
            if (cmd_wdata_i == SLT_LOCK_CLEAR) begin
                lock_bits_q[cmd_sector_i] <= 1'b0;
            end else if (cmd_wdata_i == SLT_LOCK_SET) begin
                lock_bits_q[cmd_sector_i] <= 1'b1;
            end
        end
    end

    // ========================================
    // Marks the first edge after reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rst_seen_q <= 1'b1;
        end else begin
            rst_seen_q <= 1'b0;
        end
    end

    // ========================================
    // Stored pattern, programmable once after each reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stored_q      <= SLT_STORED_RESET;
            stored_done_q <= 1'b0;
        end else if (wr_stored && !stored_done_q) begin
            stored_q      <= cmd_wdata_i;
            stored_done_q <= 1'b1;
        end
    end

    // ========================================
    // Live pattern copy
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            live_q <= SLT_STORED_RESET;
        end else if (rst_seen_q) begin
            live_q <= stored_q;
        end else if (wr_live) begin
            live_q <= cmd_wdata_i;
        end
    end

    // ========================================
    // Pattern driver feed
    assign pat.pattern = live_q;
    assign pat.start   = train_start_i;
    assign pat.tick    = train_tick_i;

    // ========================================
    // Pattern shifter
    slt_pattern_drive u_drive (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pat     (pat)
    );

    // ========================================
    // Pattern pins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            train_bit_o  <= 1'b0;
            train_oe_n_o <= 1'b1;
        end else begin
            train_bit_o  <= pat.bit_val;
            train_oe_n_o <= !pat.busy;
        end
    end

    // ========================================
    // Delivery state readout
    always_comb begin
        state_byte = SLT_ERASED_BYTE;
        case (cmd_item_i)
            SLT_ITEM_ARRAY:   state_byte = SLT_ERASED_BYTE;
            SLT_ITEM_OTP:     state_byte = (cmd_index_i < 10'(SLT_OTP_SEED_BYTES))
                                           ? pick_byte(OTP_SEED, cmd_index_i[3:0])
                                           : SLT_ERASED_BYTE;
            SLT_ITEM_STATUS1: state_byte = SLT_STATUS1_RESET;
            SLT_ITEM_CONFIG1: state_byte = SLT_CONFIG1_RESET;
            SLT_ITEM_BOOT:    state_byte = SLT_BOOT_RESET;
            SLT_ITEM_PASS:    state_byte = pick_byte({64'h0, SLT_PASS_RESET},
                                                     {1'b0, cmd_index_i[2:0]});
            SLT_ITEM_PLOCK:   state_byte = SLT_LOCK_SET;
            SLT_ITEM_ASP:     state_byte = cmd_index_i[0] ? SLT_ASP_RESET[15:8]
                                                          : SLT_ASP_RESET[7:0];
            default:          state_byte = SLT_ERASED_BYTE;
        endcase
    end

    // ========================================
    // Read answers, one cycle after the command
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o  <= 8'h00;
        end else begin
            rd_valid_o <= 1'b0;
            if (cmd_valid_i) begin
                case (cmd_op_i)
                    SLT_OP_RD_LOCK: begin
                        rd_valid_o <= 1'b1;
                        rd_data_o  <= lock_byte(sector_bit(lock_bits_q, cmd_sector_i));
                    end
                    SLT_OP_RD_STORED: begin
                        rd_valid_o <= 1'b1;
                        rd_data_o  <= stored_q;
                    end
                    SLT_OP_RD_LIVE: begin
                        rd_valid_o <= 1'b1;
                        rd_data_o  <= live_q;
                    end
                    SLT_OP_RD_STATE: begin
                        rd_valid_o <= 1'b1;
                        rd_data_o  <= state_byte;
                    end
                    default: begin
                        rd_valid_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ========================================
    // Protection of the addressed sector
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sector_locked_o <= 1'b0;
        end else begin
            sector_locked_o <= !sector_bit(lock_bits_q, cmd_sector_i);
        end
    end
endmodule
`default_nettype wire

//--- verif/slt_regs_chk.sv
// Port assertions for slt_regs.
// Assumes a bind from the bench; one clock.
`timescale 1ns/10ps
`default_nettype none
module slt_regs_chk
    import slt_pkg::*;
#(parameter int SECT_W = 9)(
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    input wire logic              cmd_valid_i,
    input wire logic [2:0]        cmd_op_i,
    input wire logic [SECT_W-1:0] cmd_sector_i,
    input wire logic [2:0]        cmd_item_i,
    input wire logic [9:0]        cmd_index_i,
    input wire logic [7:0]        cmd_wdata_i,
    input wire logic              train_start_i,
    input wire logic              rd_valid_o,
    input wire logic [7:0]        rd_data_o,
    input wire logic              sector_locked_o,
    input wire logic              train_oe_n_o
);
    // ========================================
    // Assertions
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic rd_c = cmd_valid_i && !cmd_op_i[0];
    wire logic st_c = cmd_valid_i && cmd_op_i == SLT_OP_RD_STATE;
    sequence clear_wr;
        cmd_valid_i && cmd_op_i == SLT_OP_WR_LOCK && cmd_wdata_i == SLT_LOCK_CLEAR;
    endsequence
    sequence same_rd;
        cmd_valid_i && cmd_op_i == SLT_OP_RD_LOCK && cmd_sector_i == $past(cmd_sector_i);
    endsequence
    read_answer_a: assert property (rd_c |=> rd_valid_o)
        else $error("read not answered");
    no_spurious_a: assert property (!rd_c |=> !rd_valid_o)
        else $error("answer without read");
    lock_protect_a: assert property (clear_wr ##1 same_rd |=> sector_locked_o && rd_data_o == 8'h00)
        else $error("cleared sector not protected");
    erased_ff_a: assert property (st_c && (cmd_item_i inside {3'h0, 3'h5, 3'h6} ||
        cmd_item_i == 3'h1 && cmd_index_i > 10'hf) |=> rd_data_o == 8'hff) else $error("erased byte wrong");
    regs_clear_a: assert property (st_c && cmd_item_i inside {3'h2, 3'h3, 3'h4} |=> rd_data_o == 8'h00)
        else $error("cleared register wrong");
    asp_value_a: assert property (st_c && cmd_item_i == 3'h7 && cmd_index_i < 10'h2 |=>
        rd_data_o == ($past(cmd_index_i) == 10'h1 ? 8'hfe : 8'h7f)) else $error("protection byte wrong");
    train_start_a: assert property (train_start_i |-> ##2 !train_oe_n_o)
        else $error("pattern not driven");
    reset_unlock_a: assert property ($rose(rst_n_i) |-> !sector_locked_o)
        else $error("sector locked after reset");
endmodule
`default_nettype wire

//--- verif/slt_host.sv
// Host model that fetches the training pattern.
// Assumes clk_i is shared with the block.
`timescale 1ns/10ps
`default_nettype none
module slt_host (
    input  wire logic clk_i,
    input  wire logic train_bit_i,
    input  wire logic train_oe_n_i,
    output logic      train_start_o,
    output logic      train_tick_o
);
    // ========================================
    // Capture, prompt or slow by gap
    initial {train_start_o, train_tick_o} = 2'h0;
    task automatic fetch(input int gap, output logic [7:0] pat);
        int n;
        n = 0;
        @(posedge clk_i) #1 train_start_o = 1'b1;
        @(posedge clk_i) #1 train_start_o = 1'b0;
        while (train_oe_n_i !== 1'b0 && n < 9) begin
            @(posedge clk_i) #1 n++;
        end
        for (int i = 7; i >= 0; i--) begin
            pat[i] = train_bit_i;
            train_tick_o = 1'b1;
            @(posedge clk_i) #1 train_tick_o = 1'b0;
            repeat (gap) @(posedge clk_i);
            #1;
        end
    endtask
endmodule
`default_nettype wire

//--- verif/slt_regs_tb.sv
// Bench for the sector lock and training pattern block.
// Assumes slt_regs, slt_regs_chk and slt_host are compiled first.
`timescale 1ns/10ps
`default_nettype none
module slt_regs_tb
    import slt_pkg::*;
;
    // ========================================
    // Stimulus and checks
    localparam logic [127:0] SEED = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
    logic       clk_i = 1'h0, rst_n_i = 1'h0, cmd_valid_i = 1'h0, train_start_i, train_tick_i;
    logic       rd_valid_o, sector_locked_o, train_bit_o, train_oe_n_o;
    logic [2:0] cmd_op_i = 3'h0, cmd_item_i = 3'h0;
    logic [8:0] cmd_sector_i = 9'h0;
    logic [9:0] cmd_index_i = 10'h0;
    logic [7:0] cmd_wdata_i = 8'h0, rd_data_o, pat;
    int         bad_count = 0, n_compared = 0, cycles = 0;
    int         it[13] = '{0, 1, 1, 1, 1, 2, 3, 4, 5, 5, 6, 7, 7};
    int         ix[13] = '{3, 0, 15, 16, 1023, 0, 0, 0, 0, 7, 0, 0, 1};
    logic [7:0] ex[13] = '{8'hff, SEED[7:0], SEED[127:120], 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff,
                           8'hff, 8'hff, 8'h7f, 8'hfe};
    slt_regs #(.OTP_SEED(SEED)) uut (
        .clk_i           (clk_i),
        .rst_n_i         (rst_n_i),
        .cmd_valid_i     (cmd_valid_i),
        .cmd_op_i        (cmd_op_i),
        .cmd_sector_i    (cmd_sector_i),
        .cmd_item_i      (cmd_item_i),
        .cmd_index_i     (cmd_index_i),
        .cmd_wdata_i     (cmd_wdata_i),
        .train_start_i   (train_start_i),
        .train_tick_i    (train_tick_i),
        .rd_valid_o      (rd_valid_o),
        .rd_data_o       (rd_data_o),
        .sector_locked_o (sector_locked_o),
        .train_bit_o     (train_bit_o),
        .train_oe_n_o    (train_oe_n_o)
    );
    slt_host host (.clk_i(clk_i), .train_bit_i(train_bit_o), .train_oe_n_i(train_oe_n_o),
                   .train_start_o(train_start_i), .train_tick_o(train_tick_i));
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [8:0] exp, input logic [8:0] got, input string nm);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cmd(input logic [2:0] op, input int s, input int i, input int x, input logic [7:0] d);
        @(posedge clk_i) #1;
        {cmd_valid_i, cmd_op_i, cmd_item_i, cmd_wdata_i} = {1'b1, op, 3'(i), d};
        {cmd_sector_i, cmd_index_i} = {9'(s), 10'(x)};
    endtask
    task automatic rd(input logic [2:0] op, input int s, input int i, input int x, input logic [7:0] e);
        cmd(op, s, i, x, 8'h00);
        @(posedge clk_i) #1 cmd_valid_i = 1'b0;
        chk({1'b1, e}, {rd_valid_o, rd_data_o}, "read");
    endtask
    task automatic reset_dut();
        @(posedge clk_i) #1 {rst_n_i, cmd_valid_i} = 2'h0;
        repeat (5) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        reset_dut();
        rd(SLT_OP_RD_LOCK, 9, 0, 0, 8'hff);
        chk(9'h0, {8'h0, sector_locked_o}, "locked");
        for (int s = 0; s < 512; s += 73) begin
            cmd(SLT_OP_WR_LOCK, s, 0, 0, 8'h00);
            rd(SLT_OP_RD_LOCK, s, 0, 0, 8'h00);
            @(posedge clk_i) #1 chk(9'h1, {8'h0, sector_locked_o}, "locked");
            cmd(SLT_OP_WR_LOCK, s, 0, 0, 8'h55);
            rd(SLT_OP_RD_LOCK, s, 0, 0, 8'h00);
            cmd(SLT_OP_WR_LOCK, s, 0, 0, 8'hff);
            rd(SLT_OP_RD_LOCK, s, 0, 0, 8'hff);
        end
        foreach (it[k]) rd(SLT_OP_RD_STATE, 0, it[k], ix[k], ex[k]);
        rd(SLT_OP_RD_STORED, 0, 0, 0, 8'h00);
        host.fetch(3, pat);
        chk(9'h0, {1'b0, pat}, "pattern");
        cmd(SLT_OP_WR_LIVE, 0, 0, 0, 8'ha5);
        rd(SLT_OP_RD_LIVE, 0, 0, 0, 8'ha5);
        host.fetch(1, pat);
        chk(9'h0a5, {1'b0, pat}, "pattern");
        repeat (2) @(posedge clk_i);
        #1 chk(9'h1, {8'h0, train_oe_n_o}, "oe_n");
        cmd(SLT_OP_WR_STORED, 0, 0, 0, 8'h3c);
        rd(SLT_OP_RD_STORED, 0, 0, 0, 8'h3c);
        cmd(SLT_OP_WR_STORED, 0, 0, 0, 8'hc3);
        rd(SLT_OP_RD_STORED, 0, 0, 0, 8'h3c);
        cmd(SLT_OP_WR_LOCK, 7, 0, 0, 8'h00);
        rd(SLT_OP_RD_LIVE, 0, 0, 0, 8'ha5);
        reset_dut();
        rd(SLT_OP_RD_LOCK, 7, 0, 0, 8'hff);
        rd(SLT_OP_RD_LIVE, 0, 0, 0, 8'h00);
        end_of_test();
    end
endmodule
bind slt_regs slt_regs_chk #(.SECT_W(SECT_W)) chk (
    .clk_i           (clk_i),
    .rst_n_i         (rst_n_i),
    .cmd_valid_i     (cmd_valid_i),
    .cmd_op_i        (cmd_op_i),
    .cmd_sector_i    (cmd_sector_i),
    .cmd_item_i      (cmd_item_i),
    .cmd_index_i     (cmd_index_i),
    .cmd_wdata_i     (cmd_wdata_i),
    .train_start_i   (train_start_i),
    .rd_valid_o      (rd_valid_o),
    .rd_data_o       (rd_data_o),
    .sector_locked_o (sector_locked_o),
    .train_oe_n_o    (train_oe_n_o)
);
`default_nettype wire
